// >>> smbcs_map.svh
// smbcs_map.svh: register offsets, field positions, reset values and timing.
// Assumes a 32-bit AHB-Lite word map and a 100 MHz system clock.
// Operation
// - upper four control bits form status vector
// - flags report master/slave and transmit/receive
// - start flag set on start seen or made
// - start flag set: become master, start when free
// - start flag is cleared only by software
// - master stop flag: stop after next ack
// - hardware clears stop flag after stop made
// - slave: stop flag marks observed stop
// - slave: stop write turns receiver into transmitter
// - start and stop both set: stop, then start
// - ack written when receiving, sampled when transmitting
// - ack-needed flag set after each received byte
// - no ack written before clear gives nack
// - sda follows ack write; scl low till clear
// - after address nack ignore slave events till start
// - arbitration loss sets flag; slave loss is error
// - clearing event flag clears arbitration-lost flag
// - event flag set at transfer edges, bytes, loss
// - event flag set holds scl low, stalls bus; code holds scl only while master or slave
// - vector 1110 reports master start generated
// - vector 1100 nack: restart or stop
// - ack: load, stop, restart; no data gives receiver
`ifndef SMBCS_MAP_SVH
`define SMBCS_MAP_SVH
`define SMBCS_OFF_CTRL 8'h00
`define SMBCS_OFF_DATA 8'h04
`define SMBCS_OFF_CONF 8'h08
`define SMBCS_B_MASTER 7
`define SMBCS_B_TX 6
`define SMBCS_B_START 5
`define SMBCS_B_STOP 4
`define SMBCS_B_ACKNEED 3
`define SMBCS_B_ARB 2
`define SMBCS_B_ACK 1
`define SMBCS_B_SI 0
`define SMBCS_B_EN 0
`define SMBCS_CTRL_RST 8'h00
`define SMBCS_DATA_RST 8'h00
`define SMBCS_CONF_RST 1'h0
`define SMBCS_ACK_BIT 4'h8
`define SMBCS_END_BIT 4'h9
`define SMBCS_CLK_NS 10
`define SMBCS_HALF_NS 5000
`endif

// >>> smbcs_pkg.sv
// smbcs_pkg.sv: types shared by the two-wire control and status block.
// Assumes the constants of smbcs_map.svh are included where needed.
package smbcs_pkg;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_STOP, M_STOPH, M_RS, M_RSH
  } smbcs_mst_t;
endpackage

// >>> smbcs_ctl.sv
// smbcs_ctl.sv: two-wire control/status engine with an AHB-Lite register slave.
// Assumes open-drain scl/sda resolved outside, one AHB master, clk at 100 MHz.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "smbcs_map.svh"
module smbcs_ctl import smbcs_pkg::*; #(
  parameter int HALF_NS = `SMBCS_HALF_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // least half period, rounded up, never below one cycle
  localparam int HALF_I = (HALF_NS + `SMBCS_CLK_NS - 1) / `SMBCS_CLK_NS;
  localparam logic [15:0] HALF_CYC = 16'((HALF_I < 1) ? 1 : HALF_I);

  // one-hot decode {conf, data, ctrl}; only haddr[7:0] is decoded
  function automatic logic [2:0] smbcs_dec(input logic [7:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (a == `SMBCS_OFF_CTRL) begin
      s = 3'h1;
    end else if (a == `SMBCS_OFF_DATA) begin
      s = 3'h2;
    end else if (a == `SMBCS_OFF_CONF) begin
      s = 3'h4;
    end
    return s;
  endfunction

  logic scl_m1_q, scl_s_q, scl_p_q;
  logic sda_m1_q, sda_s_q, sda_p_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q;
  logic en_q;
  smbcs_mst_t state_q;
  logic [15:0] tmr_q;
  logic scl_m_q, sda_m_q, sda_d_q;
  logic go_stop_q, go_rs_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic master_q, slave_q, tx_q, adr_q, ign_q, rw_q;
  logic start_q, stop_q, ackneed_q, arb_q, ack_q, si_q;
  logic busy_q, dwr_q;
  logic scl_oe_q, sda_oe_q, scl_o_q, sda_o_q;

  // two flops on each pin, then a third stage for edge finding
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_m1_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m1_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m1_q <= scl_i;
      scl_s_q <= scl_m1_q;
      scl_p_q <= scl_s_q;
      sda_m1_q <= sda_i;
      sda_s_q <= sda_m1_q;
      sda_p_q <= sda_s_q;
    end
  end

  // bus edges and conditions, seen only through the synchronised copies
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // register bus decode
  wire take = hsel & hready & htrans[1];
  wire [2:0] rsel = smbcs_dec(haddr[7:0]);
  wire [2:0] wsel = smbcs_dec(wr_addr_q);
  wire wr_ctrl = wr_pend_q & wsel[0];
  wire wr_data = wr_pend_q & wsel[1];
  wire wr_conf = wr_pend_q & wsel[2];
  wire [7:0] wd = hwdata[7:0];
  wire ctrl_rd_stop = stop_q;
  wire [7:0] ctrl_rd = {master_q, tx_q, start_q, ctrl_rd_stop,
                        ackneed_q, arb_q, ack_q, si_q};
  wire [31:0] rd_word = rsel[0] ? {24'h000000, ctrl_rd} :
                        rsel[1] ? {24'h000000, sh_q} :
                        rsel[2] ? {31'h00000000, en_q} : 32'h00000000;

  // zero-wait slave: read data latched in the address phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= take ? haddr[7:0] : wr_addr_q;
      hrdata_q <= (take & ~hwrite) ? rd_word : hrdata_q;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // enable bit; off releases both pins and idles the engine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_q <= `SMBCS_CONF_RST;
    end else if (wr_conf) begin
      en_q <= wd[`SMBCS_B_EN];
    end
  end

  // events of the byte engine
  wire role_on = master_q | slave_q;
  wire tmr_done = tmr_q == 16'h0000;
  wire at_ack = cnt_q == `SMBCS_ACK_BIT;
  wire at_end = cnt_q == `SMBCS_END_BIT;
  wire at_zero = cnt_q == 4'h0;
  wire bit_phase = cnt_q < `SMBCS_ACK_BIT;
  wire ev_rise = role_on & scl_rise;
  wire ev_fall = role_on & scl_fall;
  wire ev_rxbyte = ev_fall & at_ack & ~tx_q;
  wire ev_txbyte = ev_fall & at_end & tx_q;
  wire ev_arb = ev_rise & bit_phase & tx_q & sh_q[7] & ~sda_s_q;
  wire ev_mstart = (state_q == M_START) & tmr_done;
  wire ev_sstart = en_q & bus_start & ~master_q & (state_q == M_IDLE);
  // only an addressed slave reports a stop; our own stop is seen after role drops
  wire ev_sstop = en_q & bus_stop & slave_q & ~master_q & ~ign_q;
  wire ev_mstop = (state_q == M_STOPH) & tmr_done & scl_s_q;
  wire ev_adr_end = ev_fall & at_end & slave_q & adr_q;
  wire si_clr = wr_ctrl & ~wd[`SMBCS_B_SI] & si_q;
  wire hw_si = ev_rxbyte | ev_txbyte | ev_arb | ev_mstart | ev_sstop;
  wire mst_go = en_q & start_q & ~slave_q & ~busy_q & ~master_q & ~si_q;
  wire w_start = wd[`SMBCS_B_START];
  wire w_stop = wd[`SMBCS_B_STOP];

  // event flag: a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      si_q <= 1'b0;
      arb_q <= 1'b0;
      ackneed_q <= 1'b0;
    end else begin
      si_q <= hw_si | (si_q & ~si_clr);
      arb_q <= ev_arb | (arb_q & ~si_clr);
      ackneed_q <= ev_rxbyte | (ackneed_q & ~si_clr);
    end
  end

  // start flag: set by hardware, never cleared by it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_q <= 1'b0;
    end else if (ev_mstart | ev_sstart) begin
      start_q <= 1'b1;
    end else if (wr_ctrl) begin
      start_q <= w_start;
    end
  end

  // stop flag: request as master, observation as slave
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stop_q <= 1'b0;
    end else if (ev_sstop) begin
      stop_q <= 1'b1;
    end else if (ev_mstop) begin
      stop_q <= 1'b0;
    end else if (wr_ctrl & (~slave_q | ~w_stop)) begin
      stop_q <= w_stop;
    end
  end

  // ack bit: outgoing value when receiving, sampled value when sending
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else if (ev_rxbyte) begin
      ack_q <= 1'b0;
    end else if (ev_rise & at_ack & tx_q) begin
      ack_q <= ~sda_s_q;
    end else if (wr_ctrl) begin
      ack_q <= wd[`SMBCS_B_ACK];
    end
  end

  // bus busy between any start and stop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else if (bus_start) begin
      busy_q <= 1'b1;
    end else if (bus_stop) begin
      busy_q <= 1'b0;
    end
  end

  // read/write bit of a slave address, kept apart from the data register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rw_q <= 1'b0;
    end else if (ev_rxbyte & adr_q) begin
      rw_q <= sh_q[0];
    end
  end

  // role and direction
  always_ff @(posedge clk) begin
    if (!resetn) begin
      master_q <= 1'b0;
      slave_q <= 1'b0;
      tx_q <= 1'b0;
      adr_q <= 1'b0;
      ign_q <= 1'b0;
    end else if (ev_arb | ~en_q) begin
      master_q <= 1'b0;
      slave_q <= 1'b0;
    end else if (ev_mstart) begin
      master_q <= 1'b1;
      tx_q <= 1'b1;
    end else if (ev_mstop) begin
      master_q <= 1'b0;
    end else if (ev_sstart) begin
      slave_q <= 1'b1;
      tx_q <= 1'b0;
      adr_q <= 1'b1;
      ign_q <= 1'b0;
    end else if (ev_sstop) begin
      slave_q <= 1'b0;
    end else if (ev_adr_end) begin
      adr_q <= 1'b0;
      slave_q <= ack_q;
      ign_q <= ~ack_q;
      tx_q <= ack_q & rw_q;
    end else if (ev_txbyte & slave_q & ~ack_q) begin
      slave_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (si_clr & master_q & tx_q & at_zero & ~dwr_q & ~w_start & ~w_stop) begin
      tx_q <= 1'b0;
    end else if (si_clr & slave_q & w_stop) begin
      tx_q <= 1'b1;
    end
  end

  // bit engine: count, shift and data drive; stalls with the event flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      sh_q <= `SMBCS_DATA_RST;
      sda_d_q <= 1'b0;
    end else if (ev_mstart | ev_sstart) begin
      cnt_q <= 4'h0;
      sda_d_q <= 1'b0;
    end else if (ev_arb | ~role_on) begin
      sda_d_q <= 1'b0;
      sh_q <= wr_data ? wd : sh_q;
    end else if (ev_rise) begin
      sh_q <= bit_phase ? {sh_q[6:0], sda_s_q} : sh_q;
      cnt_q <= 4'(cnt_q + 4'h1);
    end else if (ev_fall & at_end) begin
      cnt_q <= 4'h0;
      sda_d_q <= slave_q & adr_q & rw_q & ack_q & ~sh_q[7];
    end else if (ev_fall & ~at_zero) begin
      sda_d_q <= bit_phase & tx_q & ~sh_q[7];
    end else if (wr_ctrl & at_ack & ~tx_q) begin
      sda_d_q <= wd[`SMBCS_B_ACK];
    end else if (si_clr & at_zero & tx_q & dwr_q) begin
      // a fresh byte puts its bit 7 on sda now, unless a master stop or restart request keeps sda free
      sda_d_q <= ~sh_q[7] & ~(master_q & (w_start | w_stop));
    end else if (wr_data) begin
      sh_q <= wd;
    end
  end

  // software data load marker, for the switch to master receiver
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dwr_q <= 1'b0;
    end else if (wr_data) begin
      dwr_q <= 1'b1;
    end else if (si_clr) begin
      dwr_q <= 1'b0;
    end
  end

  // master clock generator; waits out clock stretching in every high phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= M_IDLE;
      tmr_q <= 16'h0000;
      scl_m_q <= 1'b0;
      sda_m_q <= 1'b0;
      go_stop_q <= 1'b0;
      go_rs_q <= 1'b0;
    end else if (ev_arb | ~en_q) begin
      state_q <= M_IDLE;
      scl_m_q <= 1'b0;
      sda_m_q <= 1'b0;
      go_stop_q <= 1'b0;
      go_rs_q <= 1'b0;
    end else begin
      if (si_clr & master_q) begin
        go_stop_q <= w_stop;
        go_rs_q <= w_start & ~w_stop;
      end
      case (state_q)
        M_IDLE: begin
          scl_m_q <= 1'b0;
          sda_m_q <= 1'b0;
          if (mst_go) begin
            sda_m_q <= 1'b1;
            tmr_q <= HALF_CYC;
            state_q <= M_START;
          end
        end
        M_START: begin
          if (tmr_done) begin
            scl_m_q <= 1'b1;
            tmr_q <= HALF_CYC;
            state_q <= M_LOW;
          end else begin
            tmr_q <= 16'(tmr_q - 16'h0001);
          end
        end
        M_LOW: begin
          // the low time restarts after a stall so the first bit is full width
          if (si_q) begin
            tmr_q <= HALF_CYC;
          end else if (!tmr_done) begin
            sda_m_q <= 1'b0; // start hold ends while scl is low, so bit 7 sets up
            tmr_q <= 16'(tmr_q - 16'h0001);
          end else if (go_stop_q & at_zero) begin
            go_stop_q <= 1'b0;
            sda_m_q <= 1'b1;
            tmr_q <= HALF_CYC;
            state_q <= M_STOP;
          end else if (go_rs_q & at_zero) begin
            go_rs_q <= 1'b0;
            sda_m_q <= 1'b0;
            tmr_q <= HALF_CYC;
            state_q <= M_RS;
          end else begin
            sda_m_q <= 1'b0;
            scl_m_q <= 1'b0;
            tmr_q <= HALF_CYC;
            state_q <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (!scl_s_q) begin
            tmr_q <= HALF_CYC;
          end else if (tmr_done) begin
            scl_m_q <= 1'b1;
            tmr_q <= HALF_CYC;
            state_q <= M_LOW;
          end else begin
            tmr_q <= 16'(tmr_q - 16'h0001);
          end
        end
        M_STOP, M_RS: begin
          if (tmr_done) begin
            scl_m_q <= 1'b0;
            tmr_q <= HALF_CYC;
            state_q <= (state_q == M_STOP) ? M_STOPH : M_RSH;
          end else begin
            tmr_q <= 16'(tmr_q - 16'h0001);
          end
        end
        M_STOPH: begin
          if (!scl_s_q) begin
            tmr_q <= HALF_CYC;
          end else if (tmr_done) begin
            sda_m_q <= 1'b0;
            state_q <= M_IDLE;
          end else begin
            tmr_q <= 16'(tmr_q - 16'h0001);
          end
        end
        M_RSH: begin
          if (!scl_s_q) begin
            tmr_q <= HALF_CYC;
          end else if (tmr_done) begin
            sda_m_q <= 1'b1;
            tmr_q <= HALF_CYC;
            state_q <= M_START;
          end else begin
            tmr_q <= 16'(tmr_q - 16'h0001);
          end
        end
        default: begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  // pin drivers; one flop of delay keeps every output registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      scl_oe_q <= en_q & (scl_m_q | (si_q & role_on));
      sda_oe_q <= en_q & (sda_m_q | sda_d_q);
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign scl_o = scl_o_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
endmodule

// >>> smbcs_ctl_assertions.sv
// smbcs_ctl_assertions.sv: port-level checks of the two-wire control block.
// Assumes one AHB master with hready tied to hreadyout.
`timescale 1ns/100ps
`include "smbcs_map.svh"
module smbcs_ctl_assertions #(
  parameter int HALF_NS = `SMBCS_HALF_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  localparam int HALF_CLK = HALF_NS / `SMBCS_CLK_NS;
  logic rd_q;
  logic [7:0] off_q;
  logic scl_oe_q;
  logic [15:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // remember each read address phase for its data phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_q <= 1'b0;
      off_q <= 8'h00;
    end else if (hready) begin
      rd_q <= hsel && htrans[1] && !hwrite;
      off_q <= haddr[7:0];
    end
  end
  // cycles since scl_oe last moved; a stall only lengthens it
  always_ff @(posedge clk) begin
    scl_oe_q <= scl_oe;
    if (!resetn || scl_oe != scl_oe_q) begin
      run_q <= 16'h0000;
    end else if (run_q != 16'hFFFF) begin
      // saturate so a long idle never wraps into a short phase
      run_q <= run_q + 16'h0001;
    end
  end
  sequence s_rd(logic [7:0] o);
    rd_q && off_q == o;
  endsequence
  sequence s_start_made;
    $rose(sda_oe) && !scl_oe && scl_i;
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_ready;
    $past(resetn) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_pins;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_pins: assert property (p_pins) else $error("pin driven high");
  property p_ctl_hi;
    s_rd(`SMBCS_OFF_CTRL) |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_ctl_hi: assert property (p_ctl_hi) else $error("control upper bits set");
  property p_unmap;
    rd_q && off_q > `SMBCS_OFF_CONF |-> hrdata == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stall;
    s_rd(`SMBCS_OFF_CTRL) ##0 (hrdata[7] && hrdata[0]) |-> scl_oe;
  endproperty
  a_stall: assert property (p_stall) else $error("clock released while flagged");
  property p_start;
    s_start_made |-> ##[1:1000] scl_oe;
  endproperty
  a_start: assert property (p_start) else $error("no clock after start");
  property p_phase;
    scl_oe != scl_oe_q |-> run_q >= HALF_CLK - 2;
  endproperty
  a_phase: assert property (p_phase) else $error("clock phase too short");
endmodule

bind smbcs_ctl smbcs_ctl_assertions #(.HALF_NS(HALF_NS)) chk_u (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe)
);

// >>> smbcs_slave_model.sv
// smbcs_slave_model.sv: behavioural peer on the two-wire bus.
// Assumes open-drain wires with pull-ups resolved in the bench.
`timescale 1ns/100ps
module smbcs_slave_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic clash,
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output logic ack_seen,
  output logic [7:0] stops
);
  logic scl_q, sda_q, ack_q;
  logic [3:0] bits;
  initial begin
    scl_q = 1'b1;
    sda_q = 1'b1;
    ack_q = 1'b0;
    bits = 4'h0;
    rx_byte = 8'h00;
    ack_seen = 1'b1;
    stops = 8'h00;
  end
  // wire edges seen one clk late, like a real sampler
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) bits <= 4'h0;
    if (scl && scl_q && !sda_q && sda) stops <= stops + 8'h01;
    if (scl && !scl_q) begin
      if (bits < 4'h8) rx_byte <= {rx_byte[6:0], sda};
      else ack_seen <= sda;
      bits <= bits + 4'h1;
    end
    if (!scl && scl_q) begin
      ack_q <= ack_en && bits == 4'h8;
      if (bits == 4'h9) bits <= 4'h0;
    end
  end
  // clash pulls sda low to beat the master in arbitration
  assign sda_oe = ack_q || clash;
endmodule

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the two-wire control block.
// Assumes the peer model on the wires and a 100 MHz clock.
`timescale 1ns/100ps
`include "smbcs_map.svh"
module tb_top;
  localparam logic [7:0] a_ctl = `SMBCS_OFF_CTRL;
  localparam logic [7:0] a_dat = `SMBCS_OFF_DATA;
  localparam logic [7:0] a_cnf = `SMBCS_OFF_CONF;
  logic clk, resetn, hsel, hwrite, ack_en, clash, ack_seen;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, m_sda_oe;
  logic scl_w, sda_w;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [7:0] rx_byte, stops, byt, s0;
  logic [7:0] got_q[$], exp_q[$], msk_q[$];
  int errors, tests_run, cyc, seed;
  // open-drain wires with pull-ups
  assign scl_w = !scl_oe;
  assign sda_w = !sda_oe && !m_sda_oe;
  smbcs_ctl #(.HALF_NS(100)) dut_u (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  smbcs_slave_model peer_u (
    .clk(clk), .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .clash(clash),
    .sda_oe(m_sda_oe), .rx_byte(rx_byte), .ack_seen(ack_seen), .stops(stops)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, then the comparing side of the queues
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  always @(negedge clk) begin
    while (got_q.size() > 0) begin
      tests_run++;
      if ((got_q[0] & msk_q[0]) !== exp_q[0]) begin
        errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got_q[0] & msk_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    got_q.push_back(g);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
  endtask
  // one single AHB transfer; waits on hready in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [31:0] r;
    ahb(a, 1'b0, 8'h00, r);
    cmp(r[7:0], e, m);
  endtask
  task automatic wait_si();
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 500 && !r[0]; i++) ahb(a_ctl, 1'b0, 8'h00, r);
  endtask
  task automatic send(input logic [7:0] b);
    wr(a_dat, b);
    wr(a_ctl, 8'h00);
    wait_si();
  endtask
  initial begin
    seed = 18;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ack_en = 1'b1;
    clash = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i += 4) chk(8'(i), 8'h00, 8'hFF);
    wr(8'h0C, 8'hFF);
    chk(8'h0C, 8'h00, 8'hFF);
    wr(a_cnf, 8'h01);
    chk(a_cnf, 8'h01, 8'hFF);
    wr(a_ctl, 8'h20);
    wait_si();
    chk(a_ctl, 8'hE0, 8'hFC);
    byt = 8'($random(seed)) & 8'hFE;
    send(byt);
    chk(a_ctl, 8'hC2, 8'hFE);
    cmp(rx_byte, byt, 8'hFF);
    ack_en <= 1'b0;
    send(8'($random(seed)));
    chk(a_ctl, 8'hC0, 8'hFE);
    s0 = stops;
    wr(a_ctl, 8'h30);
    wait_si();
    chk(a_ctl, 8'hE0, 8'hFC);
    cmp(stops, s0 + 8'h01, 8'hFF);
    ack_en <= 1'b1;
    send(8'($random(seed)) & 8'hFE);
    chk(a_ctl, 8'hC2, 8'hFE);
    ack_en <= 1'b0;
    wr(a_ctl, 8'h00);
    wait_si();
    chk(a_ctl, 8'h88, 8'hF8);
    chk(a_dat, 8'hFF, 8'hFF);
    wr(a_ctl, 8'h03);
    repeat (3) @(posedge clk);
    cmp({7'h00, sda_oe}, 8'h01, 8'h01);
    cmp({7'h00, scl_oe}, 8'h01, 8'h01);
    wr(a_ctl, 8'h02);
    wait_si();
    cmp({7'h00, ack_seen}, 8'h00, 8'h01);
    s0 = stops;
    wr(a_ctl, 8'h10);
    for (int i = 0; i < 600 && stops == s0; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    cmp({7'h00, ack_seen}, 8'h01, 8'h01);
    chk(a_ctl, 8'h00, 8'h11);
    wr(a_ctl, 8'h20);
    wait_si();
    ack_en <= 1'b1;
    send(8'($random(seed)) & 8'hFE);
    wr(a_dat, 8'($random(seed)) | 8'h80);
    clash <= 1'b1;
    wr(a_ctl, 8'h00);
    wait_si();
    chk(a_ctl, 8'h05, 8'h85);
    wr(a_ctl, 8'h00);
    chk(a_ctl, 8'h00, 8'h05);
    clash <= 1'b0;
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
